// File: design/ihp_pkg.sv
// Package for the input handler prioritizer: address map, field layout, timing.
// Assumes a single processor clock domain and a simple alternate-space access port.
`default_nettype none
package ihp_pkg;
    // ==========================================================
    // Address space and map
    localparam logic [7:0]  ASI_PLAIN     = 8'h01;
    localparam logic [7:0]  ASI_ALT       = 8'hC1;
    localparam logic [31:0] PAGE_BASE     = 32'h0000_1000;
    localparam int          PAGE_WORDS    = 1024;
    localparam int          GROUP_SIZE    = 16;
    // ==========================================================
    // Control word fields and sizes
    localparam int          BIT_INVERT    = 4;
    localparam int          BIT_WIDTH_HI  = 3;
    localparam int          BIT_WIDTH_LO  = 2;
    localparam int          BIT_GATE      = 1;
    localparam int          BIT_LATCH     = 0;
    localparam int          HIST_LEN      = 6;
    localparam int          NUM_CH        = 15;
    localparam int          LEVEL_W       = 4;
    // Width codes
    localparam logic [1:0]  WID_NONE      = 2'h0;
    localparam logic [1:0]  WID_ONE       = 2'h1;
    localparam logic [1:0]  WID_THREE     = 2'h2;
    localparam logic [1:0]  WID_SIX       = 2'h3;
    // ==========================================================
    // Sample clock divider default
    localparam int          SAMPLE_DIV    = 1;
endpackage
`default_nettype wire

// File: design/ihp_top.sv
// Fifteen input handlers with noise filter and latch, plus a priority encoder.
// Assumes raw inputs are asynchronous pins and the access port is on i_sys_clk.
`default_nettype none
// Contract
// - Polarised input is raw xor invert_select
// - Six-stage history shifts per sample tick
// - Latch sets on input plus width qualification
// - Latched request holds until a software write clears it
// - Output carries latch only while gated
// - Sample tick synchronous, divided by parameter
// - Software accesses control bits, not history
// - Control word bit layout 4, 3:2, 1, 0
// - Decode alternate spaces 1 or C1
// - One word per handler in page 1000
// - Group word 0 reads outputs together
// - Encode highest pending into 4-bit level
// - Gated-off handlers do not affect level
// - Channel 15 highest, channel 1 lowest
module ihp_top #(
    parameter int DIV = ihp_pkg::SAMPLE_DIV
) (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_n,
    input  wire logic [ihp_pkg::NUM_CH:1]    i_raw_in,
    input  wire logic                        i_acc_valid,
    input  wire logic                        i_acc_write,
    input  wire logic [7:0]                  i_acc_asi,
    input  wire logic [31:0]                 i_acc_addr,
    input  wire logic [31:0]                 i_acc_wdata,
    output logic      [31:0]                 o_acc_rdata,
    output logic                             o_acc_ack,
    output logic      [ihp_pkg::LEVEL_W-1:0] o_request_level_code
);
    localparam int N = ihp_pkg::NUM_CH;
    localparam int H = ihp_pkg::HIST_LEN;

    // ==========================================================
    // Address decode
    // Word index inside the handler page; zero for the group word and when not in page
    function automatic logic [9:0] word_index(input logic [7:0] asi, input logic [31:0] a);
        logic hit;
        hit = (asi == ihp_pkg::ASI_PLAIN || asi == ihp_pkg::ASI_ALT)
            && (a[31:12] == ihp_pkg::PAGE_BASE[31:12]);
        word_index = hit ? a[11:2] : 10'h000;
    endfunction

    logic [9:0] widx;
    logic       page_hit;
    assign widx     = word_index(i_acc_asi, i_acc_addr);
    assign page_hit = (i_acc_asi == ihp_pkg::ASI_PLAIN || i_acc_asi == ihp_pkg::ASI_ALT)
                      && (i_acc_addr[31:12] == ihp_pkg::PAGE_BASE[31:12]);

    // ==========================================================
    // Input synchroniser, two flops per pin
    // Only sync2 is read; sync1 may still be settling
    logic [N:1] sync1;
    logic [N:1] sync2;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= i_raw_in;
            sync2 <= sync1;
        end
    end

    // ==========================================================
    // Sample tick divider
    logic [15:0] div_cnt;
    logic [15:0] next_div_cnt;
    logic        tick;
    // One-cycle tick every DIV clocks keeps sampling locked to the core clock
    // Zero-based count, so a DIV of 1 ticks on every clock
    always_comb begin
        tick         = (div_cnt == 16'(DIV - 1));
        next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) div_cnt <= 16'h0000;
        else          div_cnt <= next_div_cnt;
    end

    // ==========================================================
    // Handlers
    logic [N:1] inv_sel, gate, latch, next_inv, next_gate, next_latch, outv;
    logic [1:0] width [N:1];
    logic [1:0] next_width [N:1];
    logic [H-1:0] hist [N:1];
    logic [H-1:0] next_hist [N:1];
    logic [N:1] pol;

    generate
        for (genvar c = 1; c <= N; c++) begin : g_ch
            logic qual;
            logic wr;
            assign pol[c] = sync2[c] ^ inv_sel[c];
            assign wr     = i_acc_valid && i_acc_write && page_hit && widx == 10'(c);
            // Filter: width code picks how much history must agree
            always_comb begin
                unique case (width[c])
                    ihp_pkg::WID_NONE:  qual = 1'b1;
                    // Taps count down from the oldest sample
                    ihp_pkg::WID_ONE:   qual = hist[c][H-1];
                    ihp_pkg::WID_THREE: qual = &hist[c][H-1:H-3];
                    ihp_pkg::WID_SIX:   qual = &hist[c];
                endcase
                next_hist[c] = tick ? {hist[c][H-2:0], pol[c]} : hist[c];
                next_inv[c]   = wr ? i_acc_wdata[ihp_pkg::BIT_INVERT] : inv_sel[c];
                next_width[c] = wr ? i_acc_wdata[ihp_pkg::BIT_WIDTH_HI:ihp_pkg::BIT_WIDTH_LO]
                                   : width[c];
                next_gate[c]  = wr ? i_acc_wdata[ihp_pkg::BIT_GATE] : gate[c];
                // Set wins over a software clear in the same cycle
                next_latch[c] = (pol[c] && qual) ? 1'b1
                              : wr ? i_acc_wdata[ihp_pkg::BIT_LATCH]
                              : latch[c];
            end
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    hist[c]    <= '0;
                    inv_sel[c] <= 1'b0;
                    width[c]   <= ihp_pkg::WID_NONE;
                    gate[c]    <= 1'b0;
                    latch[c]   <= 1'b0;
                end else begin
                    hist[c]    <= next_hist[c];
                    inv_sel[c] <= next_inv[c];
                    width[c]   <= next_width[c];
                    gate[c]    <= next_gate[c];
                    latch[c]   <= next_latch[c];
                end
            end
            assign outv[c] = latch[c] & gate[c];
        end
    endgenerate

    // ==========================================================
    // Priority encoder, highest channel wins
    // Loop runs upward, so the last hit, the highest channel, is kept
    function automatic logic [3:0] encode(input logic [N:1] req);
        logic [3:0] lvl;
        lvl = 4'h0;
        for (int k = 1; k <= N; k++) begin
            if (req[k]) lvl = 4'(k);
        end
        encode = lvl;
    endfunction

    logic [3:0]  next_level;
    logic [31:0] next_rdata;
    logic        next_ack;
    // Only gated outputs enter arbitration; read mux for the access port
    always_comb begin
        next_level = encode(outv);
        next_rdata = 32'h0000_0000;
        // Every access is acknowledged, even one that decodes to nothing
        next_ack   = i_acc_valid;
        if (i_acc_valid && !i_acc_write && page_hit) begin
            if (widx[3:0] == 4'h0 && widx[9:4] == 6'h00) begin
                next_rdata = {16'h0000, outv, 1'b0};
            end else if (widx >= 10'h001 && widx <= 10'(N)) begin
                next_rdata[ihp_pkg::BIT_INVERT] = inv_sel[widx[3:0]];
                next_rdata[ihp_pkg::BIT_WIDTH_HI:ihp_pkg::BIT_WIDTH_LO] = width[widx[3:0]];
                next_rdata[ihp_pkg::BIT_GATE]   = gate[widx[3:0]];
                next_rdata[ihp_pkg::BIT_LATCH]  = latch[widx[3:0]];
            end
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_request_level_code <= 4'h0;
            o_acc_rdata          <= 32'h0000_0000;
            o_acc_ack            <= 1'b0;
        end else begin
            o_request_level_code <= next_level;
            o_acc_rdata          <= next_rdata;
            o_acc_ack            <= next_ack;
        end
    end

    // ==========================================================
    // Checks
    // Handler 1 stands in for all fifteen: they share one generate body,
    // so a fault there shows up on every channel
    a_gate_blocks_level: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) (outv == '0) |=> (o_request_level_code == 4'h0))
        else $error("level set with no gated request");
    a_top_channel_wins: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) outv[N] |=> (o_request_level_code == 4'(N)))
        else $error("channel 15 did not win");
    a_latch_holds: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) (latch[1] && !(i_acc_valid && i_acc_write)) |=> latch[1])
        else $error("latch dropped by itself");
    a_polarity_sets: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) (pol[1] && width[1] == ihp_pkg::WID_NONE) |=> latch[1])
        else $error("latch not set by polarised input");
    a_six_filter: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) (!latch[1] && width[1] == ihp_pkg::WID_SIX && !(&hist[1])
        && !(i_acc_valid && i_acc_write)) |=> !latch[1])
        else $error("six-sample filter passed early");
    a_hist_shift: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) tick |=> (hist[1][0] == $past(pol[1])))
        else $error("history did not shift");
    a_gate_output: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) !gate[1] |=> (o_request_level_code != 4'h1))
        else $error("level 1 shown while handler 1 gated off");
    a_ack_follows: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) i_acc_valid |=> o_acc_ack)
        else $error("access not acknowledged");
    a_foreign_space: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) (i_acc_valid && i_acc_write && i_acc_asi != ihp_pkg::ASI_PLAIN
        && i_acc_asi != ihp_pkg::ASI_ALT) |=> $stable(gate))
        else $error("write in a foreign space changed a gate");
    a_soft_clear: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) (i_acc_valid && i_acc_write && widx == 10'h001 && !pol[1]
        && !i_acc_wdata[ihp_pkg::BIT_LATCH]) |=> !latch[1])
        else $error("software clear of the latch was lost");
endmodule
`default_nettype wire

// File: dv/ihp_core_model.sv
// Processor core side model: registers the request level code once per clock.
// Assumes the level is driven on the same clock as the core and never answered.
`default_nettype none
module ihp_core_model (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_rst_n,
    input  wire logic [ihp_pkg::LEVEL_W-1:0] i_request_level_code,
    output logic      [ihp_pkg::LEVEL_W-1:0] o_taken_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Core samples the level; a one-cycle glitch would show up here too
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_taken_level <= 4'h0;
        else          o_taken_level <= i_request_level_code;
    end
endmodule
`default_nettype wire

// File: dv/test_input_handler_prioritizer.sv
// Self-checking bench for the input handler prioritizer and a core model.
// Assumes the access port answers exactly one cycle after each request.
`default_nettype none
module test_input_handler_prioritizer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, valid = 0, wr = 0, ack;
    logic [15:1] raw = '0, l, g;
    logic [7:0]  asi = 8'h01;
    logic [31:0] addr = '0, wd = '0, rdata, rd;
    logic [3:0]  lvl, core_lvl;
    logic [11:0] pat;
    int          mismatches = 0, num_checks = 0, seed = 32'h12D9;
    // ==========================================================
    // Clock, design and core model
    always #2 clk = ~clk;
    ihp_top #(.DIV(1)) ihp_top_i (.i_sys_clk(clk), .i_rst_n(rst_n), .i_raw_in(raw),
        .i_acc_valid(valid), .i_acc_write(wr), .i_acc_asi(asi), .i_acc_addr(addr),
        .i_acc_wdata(wd), .o_acc_rdata(rdata), .o_acc_ack(ack),
        .o_request_level_code(lvl));
    ihp_core_model ihp_core_model_i (.i_sys_clk(clk), .i_rst_n(rst_n),
        .i_request_level_code(lvl), .o_taken_level(core_lvl));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One access: request held over one rising edge, answer read a cycle later
    task automatic acc(input logic w, input logic [7:0] s, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(negedge clk);
        valid = 1; wr = w; asi = s; addr = a; wd = d;
        @(negedge clk);
        valid = 0;
        check({31'h0, ack}, 32'h1);
        r = rdata;
    endtask
    function automatic logic [31:0] top_ch(input logic [15:1] v);
        top_ch = 0;
        for (int i = 1; i <= 15; i++) if (v[i]) top_ch = i;
    endfunction
    task automatic finish_test;
        $display("Counts: %0d checks, %0d mismatches", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        mismatches++;
        $display("[ERR] %0t run timed out", $time);
        finish_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1;
        for (int n = 1; n <= 15; n++) begin
            acc(0, 8'h01, 32'h1000 + 4 * n, 0, rd);
            check(rd, 0);
        end
        check({28'h0, lvl}, 0);
        $display("reset test done");
        // Decode: unused bits dropped, foreign space and page ignored
        acc(1, 8'hC1, 32'h1008, 32'hFFFF_FFEE, rd);
        acc(0, 8'h01, 32'h1008, 0, rd);
        check(rd, 32'hE);
        acc(1, 8'h02, 32'h1008, 0, rd);
        acc(1, 8'h01, 32'h2008, 0, rd);
        acc(0, 8'h01, 32'h1008, 0, rd);
        check(rd, 32'hE);
        acc(0, 8'h02, 32'h1008, 0, rd);
        check(rd, 0);
        check({28'h0, lvl}, 0);
        acc(1, 8'h01, 32'h1008, 0, rd);
        $display("decode test done");
        // Inverted idle input raises a request on handler 5
        acc(1, 8'h01, 32'h1014, 32'h12, rd);
        repeat (6) @(negedge clk);
        acc(0, 8'h01, 32'h1014, 0, rd);
        check(rd, 32'h13);
        check({28'h0, lvl}, 5);
        acc(1, 8'h01, 32'h1014, 32'h10, rd);
        acc(1, 8'h01, 32'h1014, 0, rd);
        acc(1, 8'h01, 32'h1014, 0, rd);
        acc(0, 8'h01, 32'h1014, 0, rd);
        check(rd, 0);
        $display("polarity test done");
        // Random latch and gate sets, first two hand-picked corners
        for (int i = 0; i < 20; i++) begin
            l = (i < 2) ? '1 : 15'($random(seed));
            g = (i == 0) ? '1 : (i == 1) ? '0 : 15'($random(seed));
            for (int n = 1; n <= 15; n++) acc(1, 8'h01, 32'h1000 + 4 * n, 32'({g[n], l[n]}), rd);
            repeat (3) @(negedge clk);
            check({28'h0, lvl}, top_ch(l & g));
            check({28'h0, core_lvl}, top_ch(l & g));
            acc(0, 8'h01, 32'h1000, 0, rd);
            check(rd, {16'h0, l & g, 1'b0});
        end
        for (int n = 1; n <= 15; n++) acc(1, 8'h01, 32'h1000 + 4 * n, 0, rd);
        $display("priority test done");
        // Filter: pattern k passes exactly the width codes 0 to k
        for (int k = 0; k < 4; k++) begin
            // Two high; one, gap of five, one; three, gap of three, one; twelve high
            pat = (k == 0) ? 12'h003 : (k == 1) ? 12'h041 : (k == 2) ? 12'h047 : 12'hFFF;
            for (int w = 0; w < 4; w++) begin
                acc(1, 8'h01, 32'h100C, 32'(w * 4 + 2), rd);
                for (int j = 0; j < 12; j++) begin
                    raw[3] = pat[j];
                    @(negedge clk);
                end
                raw[3] = 0;
                repeat (10) @(negedge clk);
                acc(0, 8'h01, 32'h100C, 0, rd);
                check(rd, 32'(w * 4 + 2 + int'(w <= k)));
                check({28'h0, lvl}, (w <= k) ? 3 : 0);
            end
        end
        $display("filter test done");
        finish_test();
    end
endmodule
`default_nettype wire
